// ===== pkg/itp_defines.vh
// Purpose: constants for the prescaled interval timer
// Assumes: 4-bit register offset, 8-bit data bus
// Notes:   definitions only
`ifndef ITP_DEFINES_VH
`define ITP_DEFINES_VH
`define ITP_ADDR_W        4
`define ITP_DATA_W        8
`define ITP_TIMER_LO      4'h4
`define ITP_TIMER_HI      4'hf
`define ITP_STATUS_ADDR   4'h0
`define ITP_IRQ_BIT       7
`define ITP_SEL_LSB       0
`define ITP_SEL_MSB       1
`define ITP_SEL_DIV1      2'h0
`define ITP_SEL_DIV8      2'h1
`define ITP_SEL_DIV64     2'h2
`define ITP_SEL_DIV1024   2'h3
`define ITP_DIV1          11'h001
`define ITP_DIV8          11'h008
`define ITP_DIV64         11'h040
`define ITP_DIV1024       11'h400
`define ITP_PRE_W         11
`define ITP_CNT_RESET     8'hff
`endif

// ===== src/itp_prescaler.v
// Purpose: prescale divider giving a one-cycle enable pulse
// Assumes: period loaded on restart, at least 1
// Notes:   restart aligns the first pulse to the new period
`timescale 1ns/10ps
`include "itp_defines.vh"
module itp_prescaler #(
  parameter PRE_W = `ITP_PRE_W
) (
  input  wire             clk,      // block clock
  input  wire             rst,      // synchronous reset
  input  wire             restart,  // reload period and restart
  input  wire [PRE_W-1:0] period,   // cycles per tick
  output reg              tick      // one-cycle enable
);
  reg [PRE_W-1:0] remain;
  reg [PRE_W-1:0] held;

  always @(posedge clk) begin
    if (rst) begin
      remain <= {PRE_W{1'b0}};
      held   <= {{(PRE_W-1){1'b0}}, 1'b1};
      tick   <= 1'b0;
    end else if (restart) begin
      held   <= period;
      remain <= period - {{(PRE_W-1){1'b0}}, 1'b1};
      tick   <= 1'b0;
    end else if (remain == {PRE_W{1'b0}}) begin
      remain <= held - {{(PRE_W-1){1'b0}}, 1'b1};
      tick   <= 1'b1;
    end else begin
      remain <= remain - {{(PRE_W-1){1'b0}}, 1'b1};
      tick   <= 1'b0;
    end
  end
endmodule

// ===== src/itp_timer.v
// Purpose: prescaled interval timer behind an 8-bit processor port
// Assumes: one clock, processor strobes synchronous to REF_CLK
// Notes:   status read at offset 0, timer at offsets 4 to f
`timescale 1ns/10ps
`include "itp_defines.vh"
// Overview of operation
// - offsets four through fifteen all reach timer
// - write address selects the prescale division
// - written byte plus one is number of counting states
// - after zero, decrement every clock cycle
// - expiry sets status bit seven
// - counter read clears status bit seven
// - post-zero value reads as two's complement
module itp_timer #(
  parameter PRE_W = `ITP_PRE_W
) (
  input  wire                    REF_CLK,   // 250 MHz clock
  input  wire                    RESET,     // synchronous, active high
  input  wire                    CS,        // timer block select
  input  wire                    WR,        // write strobe, one cycle
  input  wire                    RD,        // read strobe, one cycle
  input  wire [`ITP_ADDR_W-1:0]  ADDR,      // register offset
  input  wire [`ITP_DATA_W-1:0]  WDATA,     // write data
  output reg  [`ITP_DATA_W-1:0]  RDATA,     // read data, valid after RD
  output reg                     RVALID,    // read data valid pulse
  output reg                     IRQ        // timer interrupt flag
);
  reg  [`ITP_DATA_W-1:0] count;
  reg                    expired;
  reg  [PRE_W-1:0]       period;
  reg                    restart;
  wire                   tick;
  wire                   is_timer;
  wire                   wr_timer;
  wire                   rd_timer;
  wire                   rd_status;
  wire                   step;
  wire [`ITP_DATA_W-1:0] next_count;

  function [PRE_W-1:0] sel_period;
    input [1:0] sel;
    begin
      case (sel)
        `ITP_SEL_DIV1:  sel_period = `ITP_DIV1;
        `ITP_SEL_DIV8:  sel_period = `ITP_DIV8;
        `ITP_SEL_DIV64: sel_period = `ITP_DIV64;
        default:        sel_period = `ITP_DIV1024;
      endcase
    end
  endfunction

  // any offset from 4 to f decodes as the timer
  assign is_timer  = CS && (ADDR >= `ITP_TIMER_LO)
                        && (ADDR <= `ITP_TIMER_HI);
  assign wr_timer  = is_timer && WR;
  assign rd_timer  = is_timer && RD;
  assign rd_status = CS && RD && (ADDR == `ITP_STATUS_ADDR);
  // once expired the prescale no longer applies
  assign step       = expired ? 1'b1 : tick;
  assign next_count = count - {{(`ITP_DATA_W-1){1'b0}}, 1'b1};

  itp_prescaler #(
    .PRE_W   (PRE_W)
  ) u_pre (
    .clk     (REF_CLK),
    .rst     (RESET),
    .restart (restart),
    .period  (period),
    .tick    (tick)
  );

  always @(posedge REF_CLK) begin
    if (RESET) begin
      count   <= `ITP_CNT_RESET;
      expired <= 1'b0;
      period  <= `ITP_DIV1;
      restart <= 1'b0;
      IRQ     <= 1'b0;
      RDATA   <= {`ITP_DATA_W{1'b0}};
      RVALID  <= 1'b0;
    end else begin
      restart <= wr_timer;
      RVALID  <= rd_timer || rd_status;
      if (wr_timer) begin
        count   <= WDATA;
        period  <= sel_period(ADDR[`ITP_SEL_MSB:`ITP_SEL_LSB]);
        expired <= 1'b0;
      end else if (restart) begin
        // hold one cycle while the divider reloads
        count <= count;
      end else if (step) begin
        count <= next_count;
        // zero reached: switch to single-cycle rate
        if (count == {`ITP_DATA_W{1'b0}} && !expired)
          expired <= 1'b1;
      end
      // set wins over a read clear in the same cycle; a timer write blocks the set
      if (step && !restart && !wr_timer && !expired &&
          count == {`ITP_DATA_W{1'b0}})
        IRQ <= 1'b1;
      else if (rd_timer || wr_timer)
        IRQ <= 1'b0;
      if (rd_timer)
        RDATA <= count;
      else if (rd_status)
        RDATA <= {IRQ, {(`ITP_DATA_W-1){1'b0}}};
    end
  end
endmodule

// ===== dv/itp_assertions.sv
// Purpose: port checks for itp_timer
// Assumes: one clock, sync reset
// Notes:   bound to every itp_timer
`timescale 1ns/10ps
module itp_chk (
  input wire       REF_CLK, // clock
  input wire       RESET,   // reset
  input wire       CS,      // select
  input wire       WR,      // write
  input wire       RD,      // read
  input wire [3:0] ADDR,    // offset
  input wire [7:0] WDATA,   // data in
  input wire [7:0] RDATA,   // data out
  input wire       RVALID,  // read valid
  input wire       IRQ      // flag
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  wire tr = CS && RD && ADDR >= 4'h4;
  wire tw = CS && WR && ADDR >= 4'h4;
  sequence s_go; tw && ADDR[1:0] == 2'h0 && WDATA == 8'h02; endsequence
  sequence s_exp; !IRQ [*2] ##[1:4] IRQ; endsequence
  property p_rd; tr |=> RVALID; endproperty
  a_rd: assert property (p_rd) else $error("no read valid");
  property p_gap; CS && RD && ADDR inside {[1:3]} |=> !RVALID; endproperty
  a_gap: assert property (p_gap) else $error("gap answered");
  property p_src; RVALID |-> $past(CS && RD); endproperty
  a_src: assert property (p_src) else $error("stray valid");
  property p_st; CS && RD && ADDR == 4'h0 |=> RDATA == {$past(IRQ), 7'h00};
  endproperty
  a_st: assert property (p_st) else $error("status bad");
  property p_clr; IRQ && tr && !WR |=> !IRQ; endproperty
  a_clr: assert property (p_clr) else $error("flag kept");
  property p_wclr; tw |=> !IRQ; endproperty
  a_wclr: assert property (p_wclr) else $error("flag after load");
  property p_hold; !RVALID |-> $stable(RDATA); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_exp; s_go |=> s_exp; endproperty
  a_exp: assert property (p_exp) else $error("expiry late");
endmodule
bind itp_timer itp_chk chk_u (.REF_CLK, .RESET, .CS, .WR, .RD, .ADDR,
  .WDATA, .RDATA, .RVALID, .IRQ);

// ===== dv/itp_timer_test.sv
// Purpose: directed checks of itp_timer
// Assumes: inputs move 1 ns after the rising edge
// Notes:   expiry judged by differences, immune to fixed latency
`timescale 1ns/10ps
module itp_timer_test;
  reg        clk = 0, rst = 1, cs = 0, wr = 0, rd = 0;
  reg  [3:0] addr = 0;
  reg  [7:0] wd = 0, v;
  wire [7:0] rdata;
  wire       rvalid, irq;
  integer    error_cnt = 0, cmp_count = 0, cyc = 0, t0, d1, d2, i;
  itp_timer dut_u (.REF_CLK(clk), .RESET(rst), .CS(cs), .WR(wr), .RD(rd),
    .ADDR(addr), .WDATA(wd), .RDATA(rdata), .RVALID(rvalid), .IRQ(irq));
  initial forever #2 clk = ~clk;
  task end_of_test;
    begin
      if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      end_of_test;
    end
  end
  task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %s exp %0h got %0h", nm, e, s);
      end
    end
  endtask
  task acc(input w, input [3:0] a, input [7:0] d);
    begin
      cs = 1;
      wr = w;
      rd = !w;
      addr = a;
      wd = d;
      @(posedge clk) #1;
      cs = 0;
      wr = 0;
      rd = 0;
    end
  endtask
  // bounded wait for expiry after a load
  task run(input [1:0] p, input [7:0] n, output integer d);
    begin
      acc(1, {2'b01, p}, n);
      t0 = cyc;
      while (irq !== 1'b1 && cyc < t0 + 8000) @(posedge clk) #1;
      d = cyc - t0;
    end
  endtask
  task s_div;
    for (i = 0; i < 4; i = i + 1) begin
      run(i[1:0], 8'h02, d1);
      run(i[1:0], 8'h04, d2);
      chk("span", d2 - d1, i == 3 ? 2048 : 2 << (3 * i));
    end
  endtask
  task s_post;
    begin
      run(2'h0, 8'h05, d1);
      acc(0, 4'h0, 8'h00);
      chk("status", rdata, 8'h80);
      acc(0, 4'h9, 8'h00);
      v = rdata;
      chk("sign", v[7], 1'b1);
      chk("irq", irq, 1'b0);
      repeat (9) @(posedge clk);
      #1 acc(0, 4'hf, 8'h00);
      // reads sampled ten edges apart, one decrement per edge
      chk("step", v - rdata, 8'h0a);
      acc(0, 4'h2, 8'h00);
      chk("gap", rvalid, 1'b0);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    s_div;
    s_post;
    end_of_test;
  end
endmodule
